// ===== rtl/gcs_pkg.sv
// Package: register map, field positions and timing constants for the governor sequencer
package gcs_pkg;
  localparam int unsigned CLK_HZ         = 25000000;
  localparam int unsigned MS_PER_S       = 1000;
  localparam int unsigned CYC_PER_MS     = CLK_HZ / MS_PER_S;
  localparam int unsigned FAILSAFE_MAX_MS = 512;
  localparam int unsigned FAILSAFE_TYP_MS = 128;
  localparam int unsigned START_RPM_TYP  = 64;

  // Register byte addresses
  localparam logic [7:0] A_FE1      = 8'h00;
  localparam logic [7:0] A_FE2      = 8'h04;
  localparam logic [7:0] A_FE3      = 8'h08;
  localparam logic [7:0] A_SENSE    = 8'h0c;
  localparam logic [7:0] A_FAILSAFE = 8'h10;
  localparam logic [7:0] A_SFUEL    = 8'h14;
  localparam logic [7:0] A_START    = 8'h18;
  localparam logic [7:0] A_RUN      = 8'h1c;
  localparam logic [7:0] A_OVSPD    = 8'h20;
  localparam logic [7:0] A_REF1     = 8'h24;
  localparam logic [7:0] A_REF2     = 8'h28;
  localparam logic [7:0] A_DELAY    = 8'h2c;
  localparam logic [7:0] A_RATES    = 8'h30;
  localparam logic [7:0] A_GAINPOS  = 8'h34;
  localparam logic [7:0] A_GAINY    = 8'h38;
  localparam logic [7:0] A_AGAIN    = 8'h3c;
  localparam logic [7:0] A_STATUS   = 8'h40;
  localparam logic [7:0] A_SPEED    = 8'h44;
  localparam logic [7:0] A_SETPT    = 8'h48;

  // Enable and sensing byte bit positions
  localparam int unsigned B_FE1_OVSPD = 6;
  localparam int unsigned B_FE2_IDLRT = 6;
  localparam int unsigned B_FE2_RAMP  = 0;
  localparam int unsigned B_FE2_AUXBS = 1;
  localparam int unsigned B_FE3_DUAL  = 6;
  localparam int unsigned B_FE3_SPGOV = 5;
  localparam int unsigned B_FE3_AGAIN = 4;
  localparam int unsigned B_FE3_SFUEL = 3;
  localparam int unsigned B_FE3_ACTRL = 0;
  localparam int unsigned B_SS_IGN    = 7;
  localparam int unsigned B_SS_TWO    = 6;
  localparam int unsigned B_SS_MPU    = 5;
  localparam logic [2:0]  CYL_MAX     = 3'h6;
  // Enable byte three bits that reach any function
  localparam logic [7:0]  FE3_USED    = 8'h79;

  localparam logic [15:0] R16_ZERO = 16'h0000;
  localparam logic [15:0] R16_ONE  = 16'h0001;
  localparam logic [15:0] POS_MAX  = 16'hffff;
  localparam logic [15:0] FS_RST   = 16'h0080;

  typedef enum logic [2:0] {
    GCS_POWERUP = 3'b000,
    GCS_START1  = 3'b001,
    GCS_START2  = 3'b010,
    GCS_RUN     = 3'b011,
    GCS_ERROR   = 3'b100
  } gcs_state_t;
endpackage : gcs_pkg

// ===== rtl/gcs_sequencer.sv
// Governor configuration decode and state sequencer with APB registers
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ps
//
// Overview of operation
// - Enable byte three bit 64 enables dual dynamics, bit 32 speed control.
// - Bit 16 enables auto-gain, bit 8 start fuel limit, bit 1 actuator control.
// - Enable byte three bits 128, 4, 2 have no effect.
// - Sensing byte bit 128 enables ignition sensing, bit 32 magnetic pickup.
// - Sensing bit 64 set means two-stroke, clear means four-stroke.
// - Cylinder count sits in sensing bits 2..0, values zero to six.
// - Single-speed operation is used when no speed-select function is on.
// - Isochronous biasing is the default when no biasing function is on.
// - Failsafe timeout is programmable from 0 to 512 ms, typically 128.
// - Start fuel limiter clamps position to its limit in first start state.
// - Power-up moves to first start when speed reaches start threshold.
// - Second start moves to run when speed reaches run threshold.
// - Run moves to error when speed exceeds overspeed threshold, if enabled.
// - Gain follows a two-point step: first gain below second position, second gain at and above.
// - Auto-gain steps gain down or up, held within min and max.
// - Idle/rated select waits a delay, then ramps from rated to idle.
// - Raise/lower ramps the setpoint with separate decrease and increase rates.
// - Active setpoint chosen by speed-select function, first reference default.
// - Overspeed protection is armed only by enable byte one bit 64.
module gcs_sequencer (
  input  wire logic                    clk_in,
  input  wire logic                    rst_n_in,
  input  wire logic                    psel_in,
  input  wire logic                    penable_in,
  input  wire logic                    pwrite_in,
  input  wire logic [7:0]              paddr_in,
  input  wire logic [31:0]             pwdata_in,
  output logic      [31:0]             prdata_out,
  output logic                         pready_out,
  output logic                         pslverr_out,
  input  wire logic [15:0]             speed_in,
  input  wire logic                    gain_down_in,
  input  wire logic                    gain_up_in,
  input  wire logic                    fault_in,
  input  wire logic [15:0]             pos_demand_in,
  output logic      [15:0]             pos_cmd_out,
  output logic      [15:0]             setpoint_out,
  output logic      [15:0]             gain_out,
  output logic      [15:0]             failsafe_cycles_out,
  output gcs_pkg::gcs_state_t          state_out,
  output logic                         ign_sense_out,
  output logic                         mpu_sense_out,
  output logic                         two_stroke_out,
  output logic      [2:0]              cylinders_out,
  output logic                         dual_dyn_out,
  output logic                         speed_ctrl_out,
  output logic                         actuator_ctrl_out,
  output logic                         single_speed_out,
  output logic                         isoch_bias_out
);
  import gcs_pkg::*;

  logic [7:0]  fe1_r, fe2_r, function_enable_third_r, speed_sensing_select_r;
  logic [15:0] failsafe_ms_r, sfuel_r, start_thr_r, run_thr_r, ovspd_thr_r;
  logic [15:0] ref1_r, ref2_r, setpoint_drop_delay_r, dec_rate_r, inc_rate_r;
  logic [15:0] gpos1_r, gpos2_r, gy1_r, gy2_r, gmin_r, gmax_r, gdec_r, ginc_r;
  logic [15:0] setpt_r, setpt_nxt, gain_r, gain_nxt, dly_r, dly_nxt;
  gcs_state_t  state_r, state_nxt;
  logic [15:0] speed_s1_r, speed_s2_r, speed_s3_r, speed_r;

  // APB decode, zero wait states
  wire         wr_en   = psel_in && penable_in && pwrite_in;
  wire         rd_en   = psel_in && penable_in && !pwrite_in;
  wire         hit_map = paddr_in[1:0] == 2'h0 && paddr_in <= A_SETPT;
  wire [15:0]  wlo     = pwdata_in[15:0];
  wire [15:0]  whi     = pwdata_in[31:16];

  logic [31:0] rd_mux;
  always_comb begin
    unique case (paddr_in)
      A_FE1:      rd_mux = {24'h0, fe1_r};
      A_FE2:      rd_mux = {24'h0, fe2_r};
      A_FE3:      rd_mux = {24'h0, function_enable_third_r};
      A_SENSE:    rd_mux = {24'h0, speed_sensing_select_r};
      A_FAILSAFE: rd_mux = {16'h0, failsafe_ms_r};
      A_SFUEL:    rd_mux = {16'h0, sfuel_r};
      A_START:    rd_mux = {16'h0, start_thr_r};
      A_RUN:      rd_mux = {16'h0, run_thr_r};
      A_OVSPD:    rd_mux = {16'h0, ovspd_thr_r};
      A_REF1:     rd_mux = {16'h0, ref1_r};
      A_REF2:     rd_mux = {16'h0, ref2_r};
      A_DELAY:    rd_mux = {16'h0, setpoint_drop_delay_r};
      A_RATES:    rd_mux = {inc_rate_r, dec_rate_r};
      A_GAINPOS:  rd_mux = {gpos2_r, gpos1_r};
      A_GAINY:    rd_mux = {gy2_r, gy1_r};
      A_AGAIN:    rd_mux = {gmax_r, gmin_r};
      A_STATUS:   rd_mux = {15'h0, ign_sense_out, mpu_sense_out, two_stroke_out,
                            cylinders_out, state_r, 8'h0};
      A_SPEED:    rd_mux = {16'h0, speed_r};
      A_SETPT:    rd_mux = {gain_r, setpt_r};
      default:    rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      fe1_r <= 8'h0; fe2_r <= 8'h0; function_enable_third_r <= 8'h0;
      speed_sensing_select_r <= 8'h0;
      failsafe_ms_r <= FS_RST; sfuel_r <= POS_MAX; start_thr_r <= R16_ZERO;
      run_thr_r <= R16_ZERO; ovspd_thr_r <= POS_MAX; ref1_r <= R16_ZERO;
      ref2_r <= R16_ZERO; setpoint_drop_delay_r <= R16_ZERO;
      dec_rate_r <= R16_ONE; inc_rate_r <= R16_ONE;
      gpos1_r <= R16_ZERO; gpos2_r <= POS_MAX; gy1_r <= R16_ZERO; gy2_r <= R16_ZERO;
      gmin_r <= R16_ZERO; gmax_r <= POS_MAX; gdec_r <= R16_ONE; ginc_r <= R16_ONE;
    end else if (wr_en) begin
      unique case (paddr_in)
        A_FE1:   fe1_r <= pwdata_in[7:0];
        A_FE2:   fe2_r <= pwdata_in[7:0];
        A_FE3:   function_enable_third_r <= pwdata_in[7:0];
        A_SENSE: speed_sensing_select_r <= pwdata_in[7:0];
        A_FAILSAFE: begin
          // Clamp to the documented range
          failsafe_ms_r <= (wlo > 16'(FAILSAFE_MAX_MS)) ? 16'(FAILSAFE_MAX_MS) : wlo;
        end
        A_SFUEL: sfuel_r <= wlo;
        A_START: start_thr_r <= wlo;
        A_RUN:   run_thr_r <= wlo;
        A_OVSPD: ovspd_thr_r <= wlo;
        A_REF1:  ref1_r <= wlo;
        A_REF2:  ref2_r <= wlo;
        A_DELAY: setpoint_drop_delay_r <= wlo;
        A_RATES: begin
          dec_rate_r <= wlo;
          inc_rate_r <= whi;
        end
        A_GAINPOS: begin
          gpos1_r <= wlo;
          gpos2_r <= whi;
        end
        A_GAINY: begin
          gy1_r <= wlo;
          gy2_r <= whi;
        end
        A_AGAIN: begin
          gmin_r <= wlo;
          gmax_r <= whi;
        end
        default: begin
          gdec_r <= gdec_r;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      prdata_out  <= 32'h0;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      prdata_out  <= (psel_in && !penable_in && !pwrite_in) ? rd_mux : prdata_out;
      pready_out  <= psel_in && !penable_in;
      pslverr_out <= psel_in && !penable_in && !hit_map;
    end
  end

  // Speed input from another domain: three-stage sync, accept on agreement
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      speed_s1_r <= R16_ZERO;
      speed_s2_r <= R16_ZERO;
      speed_s3_r <= R16_ZERO;
      speed_r    <= R16_ZERO;
    end else begin
      speed_s1_r <= speed_in;
      speed_s2_r <= speed_s1_r;
      speed_s3_r <= speed_s2_r;
      if (speed_s2_r == speed_s3_r) begin
        speed_r <= speed_s3_r;
      end
    end
  end

  // Configuration decode
  wire fe3_dual  = function_enable_third_r[B_FE3_DUAL];
  wire fe3_spgov = function_enable_third_r[B_FE3_SPGOV];
  wire fe3_again = function_enable_third_r[B_FE3_AGAIN];
  wire fe3_sfuel = function_enable_third_r[B_FE3_SFUEL];
  wire fe3_actrl = function_enable_third_r[B_FE3_ACTRL];
  wire [2:0] cyl = speed_sensing_select_r[2:0];
  wire cyl_ok    = cyl <= CYL_MAX;
  wire ign_on    = speed_sensing_select_r[B_SS_IGN] && cyl_ok;
  wire mpu_on    = speed_sensing_select_r[B_SS_MPU];
  wire two_st    = speed_sensing_select_r[B_SS_TWO];
  wire idlrt_on  = fe2_r[B_FE2_IDLRT];
  wire ramp_on   = fe2_r[B_FE2_RAMP];
  wire ovspd_on  = fe1_r[B_FE1_OVSPD];
  wire single_sp = !idlrt_on && !ramp_on;
  wire isoch     = !fe2_r[B_FE2_AUXBS];

  // Governor state machine
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      GCS_POWERUP: if (speed_r >= start_thr_r) state_nxt = GCS_START1;
      GCS_START1:  state_nxt = GCS_START2;
      GCS_START2:  if (speed_r >= run_thr_r) state_nxt = GCS_RUN;
      GCS_RUN: begin
        if (ovspd_on && speed_r > ovspd_thr_r) state_nxt = GCS_ERROR;
      end
      GCS_ERROR:   state_nxt = GCS_ERROR;
      default:     state_nxt = GCS_POWERUP;
    endcase
  end

  // Setpoint selection and ramps
  wire [15:0] target = (idlrt_on && !fault_in) ? ref1_r : (idlrt_on ? ref2_r : ref1_r);
  wire        delay_done = dly_r >= setpoint_drop_delay_r;
  always_comb begin
    dly_nxt   = (idlrt_on && setpt_r > ref1_r && !delay_done) ? dly_r + R16_ONE : dly_r;
    setpt_nxt = setpt_r;
    if (single_sp) begin
      setpt_nxt = ref1_r;
    end else if (idlrt_on && setpt_r > target && !delay_done) begin
      setpt_nxt = setpt_r;
    end else if (setpt_r > target) begin
      setpt_nxt = (setpt_r - target > dec_rate_r) ? setpt_r - dec_rate_r : target;
    end else if (setpt_r < target) begin
      setpt_nxt = (target - setpt_r > inc_rate_r) ? setpt_r + inc_rate_r : target;
    end
    if (setpt_r <= target) begin
      dly_nxt = R16_ZERO;
    end
  end

  // Gain curve base and auto-gain
  wire [15:0] curve = (speed_r <= gpos1_r) ? gy1_r :
                      (speed_r >= gpos2_r) ? gy2_r : gy1_r;
  always_comb begin
    gain_nxt = fe3_again ? gain_r : curve;
    if (fe3_again && gain_down_in) begin
      gain_nxt = (gain_r > gmin_r + gdec_r) ? gain_r - gdec_r : gmin_r;
    end else if (fe3_again && gain_up_in) begin
      gain_nxt = (gain_r + ginc_r < gmax_r) ? gain_r + ginc_r : gmax_r;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_r <= GCS_POWERUP;
      setpt_r <= R16_ZERO;
      gain_r  <= R16_ZERO;
      dly_r   <= R16_ZERO;
    end else begin
      state_r <= state_nxt;
      setpt_r <= setpt_nxt;
      gain_r  <= gain_nxt;
      dly_r   <= dly_nxt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pos_cmd_out <= R16_ZERO; setpoint_out <= R16_ZERO; gain_out <= R16_ZERO;
      failsafe_cycles_out <= R16_ZERO; state_out <= GCS_POWERUP;
      ign_sense_out <= 1'b0; mpu_sense_out <= 1'b0; two_stroke_out <= 1'b0;
      cylinders_out <= 3'h0; dual_dyn_out <= 1'b0; speed_ctrl_out <= 1'b0;
      actuator_ctrl_out <= 1'b0; single_speed_out <= 1'b0; isoch_bias_out <= 1'b0;
    end else begin
      pos_cmd_out <= (fe3_sfuel && state_r == GCS_START1 && pos_demand_in > sfuel_r)
                     ? sfuel_r : pos_demand_in;
      setpoint_out        <= setpt_r;
      gain_out            <= gain_r;
      failsafe_cycles_out <= failsafe_ms_r;
      state_out           <= state_r;
      ign_sense_out       <= ign_on;
      mpu_sense_out       <= mpu_on;
      two_stroke_out      <= two_st;
      cylinders_out       <= cyl;
      dual_dyn_out        <= fe3_dual;
      speed_ctrl_out      <= fe3_spgov;
      actuator_ctrl_out   <= fe3_actrl;
      single_speed_out    <= single_sp;
      isoch_bias_out      <= isoch;
    end
  end

  // Start-up climb: start1 lasts exactly one cycle
  sequence seq_start1_now;
    state_r == GCS_START1;
  endsequence
  sequence seq_start2_next;
    ##1 state_r == GCS_START2;
  endsequence

  AST_PU_TO_S1: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state_r == GCS_POWERUP && speed_r >= start_thr_r |=> state_r == GCS_START1)
    else $error("power-up did not advance");
  AST_PU_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state_r == GCS_POWERUP && speed_r < start_thr_r |=> state_r == GCS_POWERUP)
    else $error("power-up left below threshold");
  AST_S1_TO_S2: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    seq_start1_now |-> seq_start2_next)
    else $error("start1 did not advance");
  AST_S2_TO_RUN: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state_r == GCS_START2 && speed_r >= run_thr_r |=> state_r == GCS_RUN)
    else $error("start2 did not advance");
  AST_S2_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state_r == GCS_START2 && speed_r < run_thr_r |=> state_r == GCS_START2)
    else $error("start2 left below threshold");
  AST_OVSPD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state_r == GCS_RUN && ovspd_on && speed_r > ovspd_thr_r |=> state_r == GCS_ERROR)
    else $error("overspeed not taken");
  AST_RUN_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state_r == GCS_RUN && speed_r <= ovspd_thr_r |=> state_r == GCS_RUN)
    else $error("run left without overspeed");
  AST_OVSPD_OFF: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state_r == GCS_RUN && !ovspd_on |=> state_r == GCS_RUN)
    else $error("overspeed without enable");
  AST_ERR_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state_r == GCS_ERROR |=> state_r == GCS_ERROR)
    else $error("error state left before reset");
  AST_SFUEL: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    fe3_sfuel && state_r == GCS_START1 |=> pos_cmd_out <= $past(sfuel_r))
    else $error("start fuel not clamped");
  AST_SFUEL_PASS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !(fe3_sfuel && state_r == GCS_START1) |=> pos_cmd_out == $past(pos_demand_in))
    else $error("position demand altered outside start1");
  AST_GAIN_LIM: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    fe3_again && gain_down_in && gmin_r <= gmax_r |=> gain_r >= $past(gmin_r))
    else $error("gain below minimum");
  AST_GAIN_MAX: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    fe3_again && gain_up_in && !gain_down_in |=> gain_r <= $past(gmax_r))
    else $error("gain above maximum");
  AST_FE3_DEC: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    1'b1 |=> {dual_dyn_out, speed_ctrl_out, actuator_ctrl_out} ==
      $past({fe3_dual, fe3_spgov, fe3_actrl}))
    else $error("function enables not decoded");
  AST_FE3_RSVD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ((function_enable_third_r ^ $past(function_enable_third_r)) & FE3_USED) == 8'h00
      |=> $stable({dual_dyn_out, speed_ctrl_out, actuator_ctrl_out}))
    else $error("ignored enable bit changed a function");
  AST_IGN_DEC: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    1'b1 |=> ign_sense_out == $past(ign_on))
    else $error("ignition sensing not decoded");
  AST_IGN_CYL: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ign_sense_out |-> cylinders_out <= CYL_MAX)
    else $error("ignition active with bad count");
  AST_MPU_DEC: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    1'b1 |=> mpu_sense_out == $past(mpu_on))
    else $error("pickup sensing not decoded");
  AST_TWO_DEC: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    1'b1 |=> two_stroke_out == $past(two_st))
    else $error("stroke type not decoded");
  AST_CYL_DEC: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    1'b1 |=> cylinders_out == $past(cyl))
    else $error("cylinder count not decoded");
  AST_FS_MAX: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    failsafe_cycles_out <= 16'(FAILSAFE_MAX_MS))
    else $error("failsafe timeout above range");
  AST_SINGLE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    single_sp |=> setpt_r == $past(ref1_r))
    else $error("default setpoint not reference one");
  AST_ISOCH: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    1'b1 |=> isoch_bias_out == !$past(fe2_r[B_FE2_AUXBS]))
    else $error("isochronous default wrong");
  AST_SETPT_WAIT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    idlrt_on && setpt_r > target && !delay_done |=> setpt_r == $past(setpt_r))
    else $error("setpoint dropped before delay");
  AST_RAMP_DN: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !single_sp && setpt_r > target |=> setpt_r >= $past(target))
    else $error("setpoint ramp overshot downward");
  AST_RAMP_UP: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !single_sp && setpt_r < target |=> setpt_r <= $past(target))
    else $error("setpoint ramp overshot upward");
  AST_SPEED_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    speed_s2_r != speed_s3_r |=> speed_r == $past(speed_r))
    else $error("speed taken while stages disagree");
  AST_PREADY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    1'b1 |=> pready_out == $past(psel_in && !penable_in))
    else $error("ready not in access cycle");
  AST_PSLVERR: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    psel_in && !penable_in && !hit_map |=> pslverr_out)
    else $error("unmapped access not flagged");
endmodule : gcs_sequencer

// ===== dv/gcs_tool_model.sv
// Service tool model: APB master that vets and downloads parameter files
`timescale 1ns/1ps
module gcs_tool_model (
  input  wire logic        clk_in,
  output logic             psel_out,
  output logic             penable_out,
  output logic             pwrite_out,
  output logic [7:0]       paddr_out,
  output logic [31:0]      pwdata_out,
  input  wire logic [31:0] prdata_in,
  input  wire logic        pready_in,
  input  wire logic        pslverr_in
);
  initial begin
    psel_out    = 1'b0;
    penable_out = 1'b0;
    pwrite_out  = 1'b0;
    paddr_out   = 8'h00;
    pwdata_out  = 32'h0;
  end

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge clk_in);
    psel_out    <= 1'b1;
    pwrite_out  <= wr;
    paddr_out   <= a;
    pwdata_out  <= d;
    @(posedge clk_in);
    penable_out <= 1'b1;
    do @(posedge clk_in); while (pready_in !== 1'b1);
    rd = prdata_in;
    err = pslverr_in;
    psel_out    <= 1'b0;
    penable_out <= 1'b0;
    // Released bus shows no stale values
    paddr_out   <= ~a;
    pwdata_out  <= ~d;
  endtask : xfer

  task automatic download(input string lines[$], input logic [7:0] base,
                          output logic refused);
    int v;
    int lo;
    int hi;
    int vals[$];
    logic [31:0] rd;
    logic e;
    refused = 1'b0;
    lo = 0;
    hi = 0;
    foreach (lines[i]) begin
      if (lines[i].substr(0, 0) == ";") begin
        void'($sscanf(lines[i], "; lower bound: %d", lo));
        void'($sscanf(lines[i], "; upper bound: %d", hi));
      end else if ($sscanf(lines[i], "%d", v) == 1) begin
        if (v < lo || v > hi) refused = 1'b1;
        vals.push_back(v);
      end
    end
    // File order maps onto consecutive registers
    if (!refused) foreach (vals[i]) xfer(1'b1, base + 8'(4 * i), 32'(vals[i]), rd, e);
  endtask : download
endmodule : gcs_tool_model

// ===== dv/gcs_sequencer_tb.sv
// Testbench for the governor sequencer: registers, decode and state checks
`timescale 1ns/1ps
module gcs_sequencer_tb;
  import gcs_pkg::*;
  logic        clk_in, rst_n_in, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, b;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] speed, pos_dem, pos_cmd, setpt, gain, fs_cyc, pd;
  logic        gain_dn, gain_up, fault, spark_pulse_input, mpu, two, dual, spd, act, single, isoch, e, v;
  logic [2:0]  cyl;
  gcs_state_t  state;
  int          mismatches, n_checks;

  gcs_tool_model tool (.clk_in(clk_in), .psel_out(psel), .penable_out(penable),
    .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata), .prdata_in(prdata),
    .pready_in(pready), .pslverr_in(pslverr));
  gcs_sequencer dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .speed_in(speed),
    .gain_down_in(gain_dn), .gain_up_in(gain_up), .fault_in(fault), .pos_demand_in(pos_dem),
    .pos_cmd_out(pos_cmd), .setpoint_out(setpt), .gain_out(gain), .failsafe_cycles_out(fs_cyc),
    .state_out(state), .ign_sense_out(spark_pulse_input), .mpu_sense_out(mpu), .two_stroke_out(two),
    .cylinders_out(cyl), .dual_dyn_out(dual), .speed_ctrl_out(spd), .actuator_ctrl_out(act),
    .single_speed_out(single), .isoch_bias_out(isoch));

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  always @(posedge clk_in) pos_dem <= 16'($urandom);

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    tool.xfer(1'b1, a, d, r, e);
    chk(32'(e), 32'h0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    tool.xfer(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask : cyc

  task automatic wait_state(input gcs_state_t s, input int n);
    for (int k = 0; k < n && state !== s; k++) @(posedge clk_in);
    chk(32'(state), 32'(s));
  endtask : wait_state

  task automatic wait_sp(input logic [15:0] s, input int n);
    for (int k = 0; k < n && setpt !== s; k++) @(posedge clk_in);
    chk(32'(setpt), 32'(s));
  endtask : wait_sp

  initial begin
    #(40 * 60000);
    mismatches++;
    test_done();
  end

  initial begin
    void'($urandom(61466));
    {rst_n_in, speed, gain_dn, gain_up, fault} = '0;
    repeat (12) @(posedge clk_in);
    chk(32'(state), 32'(GCS_POWERUP));
    rst_n_in <= 1'b1;
    // Thresholds of zero are met by a standing engine
    wait_state(GCS_RUN, 40);
    repeat (20) begin
      cyc(1);
      pd = pos_dem;
      cyc(1);
      chk(32'(pos_cmd), 32'(pd));
    end
    rd(A_FAILSAFE, 32'(FAILSAFE_TYP_MS));
    chk({single, isoch}, 2'b11);
    tool.xfer(1'b1, 8'h4c, 32'hffffffff, r, e);
    chk(32'(e), 32'h1);
    tool.xfer(1'b0, 8'h0a, 32'h0, r, e);
    chk(r, 32'h0);
    chk(32'(e), 32'h1);
    wr(A_FAILSAFE, 32'd600);
    rd(A_FAILSAFE, 32'(FAILSAFE_MAX_MS));
    chk(32'(fs_cyc), 32'(FAILSAFE_MAX_MS));
    for (int i = 0; i < 40; i++) begin
      b = (i < 8) ? 8'(1 << i) : 8'($urandom);
      wr(A_FE3, {24'h0, b});
      cyc(2);
      chk({dual, spd, act}, {b[6], b[5], b[0]});
      rd(A_FE3, {24'h0, b});
    end
    for (int i = 0; i < 40; i++) begin
      b = (i < 8) ? (8'h80 | 8'(i)) : 8'($urandom);
      wr(A_SENSE, {24'h0, b});
      cyc(2);
      v = b[7] && (b[2:0] <= CYL_MAX);
      chk({spark_pulse_input, mpu}, {v, b[5]});
      if (v) chk({two, cyl}, {b[6], b[2:0]});
    end
    tool.download('{"; lower bound: 0", "; upper bound: 100", "64",
                    "; lower bound: 0", "; upper bound: 1000", "900"}, A_START, e);
    chk(32'(e), 32'h0);
    rd(A_START, 32'd64);
    rd(A_RUN, 32'd900);
    tool.download('{"; lower bound: 0", "; upper bound: 1000", "5000"}, A_RUN, e);
    chk(32'(e), 32'h1);
    rd(A_RUN, 32'd900);
    wr(A_REF1, 32'd1000);
    wr(A_REF2, 32'd1100);
    wr(A_DELAY, 32'd20);
    wait_sp(16'd1000, 3000);
    wr(A_FE2, 32'h40);
    fault <= 1'b1;
    wait_sp(16'd1100, 3000);
    chk(32'(single), 32'h0);
    fault <= 1'b0;
    cyc(15);
    chk(32'(setpt), 32'd1100);
    wait_sp(16'd1000, 3000);
    wr(A_FE2, 32'h02);
    cyc(2);
    chk(32'(isoch), 32'h0);
    wr(A_FE2, 32'h00);
    wr(A_AGAIN, {16'd8, 16'd5});
    wr(A_FE3, 32'h10);
    gain_up <= 1'b1;
    cyc(30);
    chk(32'(gain), 32'd8);
    gain_up <= 1'b0;
    gain_dn <= 1'b1;
    cyc(30);
    chk(32'(gain), 32'd5);
    gain_dn <= 1'b0;
    rd(A_SETPT, {16'd5, 16'd1000});
    wr(A_OVSPD, 32'd1100);
    speed <= 16'd1100;
    cyc(10);
    chk(32'(state), 32'(GCS_RUN));
    speed <= 16'd1200;
    cyc(10);
    chk(32'(state), 32'(GCS_RUN));
    wr(A_FE1, 32'h40);
    wait_state(GCS_ERROR, 20);
    tool.xfer(1'b0, A_STATUS, 32'h0, r, e);
    chk(32'(r[10:8]), 32'(GCS_ERROR));
    wr(A_GAINPOS, {16'd1000, 16'd500});
    wr(A_GAINY, {16'd22, 16'd11});
    wr(A_FE3, 32'h00);
    cyc(3);
    chk(32'(gain), 32'd22);
    speed <= 16'd100;
    cyc(8);
    chk(32'(gain), 32'd11);
    // Second reset in mid-run leaves the error state
    rst_n_in <= 1'b0;
    cyc(3);
    chk(32'(state), 32'(GCS_POWERUP));
    rst_n_in <= 1'b1;
    wait_state(GCS_RUN, 40);
    rd(A_FE3, 32'h0);
    test_done();
  end
endmodule : gcs_sequencer_tb
